/* hdl/clk_protect_pkg.sv */
// Constants for the clock protection and oscillation stop detector
package clk_protect_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] WRITE_PROTECT_ADDR = 8'h00;
  localparam logic [7:0] PROC_MODE2_ADDR = 8'h01;
  localparam logic [7:0] CLK_CTRL0_ADDR = 8'h02;
  localparam logic [7:0] CLK_CTRL1_ADDR = 8'h03;
  localparam logic [7:0] CLK_CTRL2_ADDR = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h05;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h06;
  // Field positions
  localparam int CLK_UNLOCK_BIT = 0;
  localparam int MODE_UNLOCK_BIT = 1;
  localparam int LOCK_BIT = 1;
  localparam int WAIT_PERIPH_BIT = 2;
  localparam int MAIN_HALT_BIT = 5;
  localparam int SUB_CPU_BIT = 7;
  localparam int ALL_STOP_BIT = 0;
  localparam int RING_STOP_BIT = 4;
  localparam int DET_EN_BIT = 0;
  localparam int RING_CPU_BIT = 1;
  localparam int EVT_FLAG_BIT = 2;
  localparam int MAIN_STATE_BIT = 3;
  localparam int ACTION_BIT = 7;
  localparam int STOP_IRQ_BIT = 0;
  localparam int REOSC_IRQ_BIT = 1;
  localparam int IRQ_W = 2;
  // Reset values
  localparam logic RING_STOP_RST = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  // Timing of the reference window
  localparam int CLK_PERIOD_NS = 40;
  localparam int REF_PERIOD_NS = 8000;
  localparam int WIN_CYCLES = REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WIN_W = $clog2(WIN_CYCLES);
endpackage : clk_protect_pkg

/* hdl/clock_protect_osc_stop_detect.sv */
// Clock protection lock and main oscillator stop / re-oscillation detector
//
// Design decisions made here: the address map and the plain strobed port.
module clock_protect_osc_stop_detect (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [clk_protect_pkg::ADDR_W-1:0] addr_in,
  input wire logic [clk_protect_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [clk_protect_pkg::DATA_W-1:0] rdata_out,
  // Oscillator and watchdog
  input wire logic main_osc_input_in,
  input wire logic wdt_irq_in,
  // Clock control
  output logic wait_periph_clock_stop_out,
  output logic main_clock_halt_out,
  output logic subclock_cpu_select_out,
  output logic all_clock_stop_out,
  output logic ring_osc_stop_out,
  output logic ring_osc_cpu_select_out,
  output logic periph_on_ring_out,
  // Reset and interrupt
  output logic osc_stop_reset_out,
  output logic irq_out
);
  localparam int WW = clk_protect_pkg::WIN_W;
  localparam logic [WW-1:0] WIN_LAST = WW'(clk_protect_pkg::WIN_CYCLES - 1);

  logic clk_unlock_reg, clk_unlock_next, mode_unlock_reg, mode_unlock_next;
  logic lock_reg, lock_next, wait_periph_reg, wait_periph_next;
  logic halt_reg, halt_next, sub_cpu_reg, sub_cpu_next;
  logic all_stop_reg, all_stop_next, ring_stop_reg, ring_stop_next;
  logic det_en_reg, det_en_next, action_reg, action_next;
  logic ring_cpu_reg, ring_cpu_next, flag_reg, flag_next;
  logic main_state_reg, main_state_next, hold_reg, hold_next;
  logic periph_ring_reg, periph_ring_next, irq_reg, irq_next;
  logic [clk_protect_pkg::IRQ_W-1:0] status_reg, status_next, mask_reg, mask_next;
  logic [clk_protect_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic osc_prev_reg, seen_reg, seen_next;
  logic [WW-1:0] win_reg, win_next;
  logic win_end, stop_evt, reosc_evt, evt, irq_req;
  logic wr_prot, wr_pm2, wr_cm0, wr_cm1, wr_cm2;

  always_comb begin
    wr_prot = wr_in && addr_in == clk_protect_pkg::WRITE_PROTECT_ADDR;
    wr_pm2 = wr_in && addr_in == clk_protect_pkg::PROC_MODE2_ADDR && mode_unlock_reg;
    wr_cm0 = wr_in && addr_in == clk_protect_pkg::CLK_CTRL0_ADDR && clk_unlock_reg;
    wr_cm1 = wr_in && addr_in == clk_protect_pkg::CLK_CTRL1_ADDR && clk_unlock_reg;
    wr_cm2 = wr_in && addr_in == clk_protect_pkg::CLK_CTRL2_ADDR && clk_unlock_reg;
    // Edge detection over one reference window
    win_end = win_reg == WIN_LAST;
    win_next = (!det_en_reg || win_end) ? '0 : win_reg + 1'b1;
    seen_next = det_en_reg && !win_end && (seen_reg || (main_osc_input_in != osc_prev_reg));
    stop_evt = det_en_reg && win_end && !seen_reg && !main_state_reg;
    reosc_evt = det_en_reg && win_end && seen_reg && main_state_reg;
    evt = stop_evt || reosc_evt;
    irq_req = evt && action_reg && !flag_reg;
    // Software writes
    clk_unlock_next = wr_prot ? wdata_in[clk_protect_pkg::CLK_UNLOCK_BIT] : clk_unlock_reg;
    mode_unlock_next = wr_prot ? wdata_in[clk_protect_pkg::MODE_UNLOCK_BIT] : mode_unlock_reg;
    lock_next = wr_pm2 ? wdata_in[clk_protect_pkg::LOCK_BIT] : lock_reg;
    wait_periph_next = wait_periph_reg;
    halt_next = halt_reg;
    sub_cpu_next = sub_cpu_reg;
    all_stop_next = all_stop_reg;
    det_en_next = det_en_reg;
    if (wr_cm0 && !lock_reg) begin
      wait_periph_next = wdata_in[clk_protect_pkg::WAIT_PERIPH_BIT];
      halt_next = wdata_in[clk_protect_pkg::MAIN_HALT_BIT];
      sub_cpu_next = wdata_in[clk_protect_pkg::SUB_CPU_BIT];
    end
    if (wr_cm1 && !lock_reg) begin
      all_stop_next = wdata_in[clk_protect_pkg::ALL_STOP_BIT];
    end
    if (wr_cm2 && !lock_reg) begin
      det_en_next = wdata_in[clk_protect_pkg::DET_EN_BIT];
    end
    ring_stop_next = wr_cm1 ? wdata_in[clk_protect_pkg::RING_STOP_BIT] : ring_stop_reg;
    action_next = wr_cm2 ? wdata_in[clk_protect_pkg::ACTION_BIT] : action_reg;
    ring_cpu_next = wr_cm2 ? wdata_in[clk_protect_pkg::RING_CPU_BIT] : ring_cpu_reg;
    // Flag cleared only by software or the stop reset hold, a set wins over a software clear in the same cycle
    flag_next = flag_reg && !(wr_cm2 && !wdata_in[clk_protect_pkg::EVT_FLAG_BIT]);
    main_state_next = main_state_reg;
    if (stop_evt) begin
      main_state_next = 1'b1;
    end
    if (reosc_evt) begin
      main_state_next = 1'b0;
    end
    if (irq_req) begin
      flag_next = 1'b1;
      ring_stop_next = 1'b0;
      if (stop_evt && !sub_cpu_reg) begin
        ring_cpu_next = 1'b1;
      end
    end
    hold_next = hold_reg || (evt && !action_reg);
    // Interrupt status, read clears, set wins
    status_next = status_reg;
    if (rd_in && addr_in == clk_protect_pkg::IRQ_STATUS_ADDR) begin
      status_next = '0;
    end
    status_next[clk_protect_pkg::STOP_IRQ_BIT] |= irq_req && stop_evt;
    status_next[clk_protect_pkg::REOSC_IRQ_BIT] |= irq_req && reosc_evt;
    mask_next = (wr_in && addr_in == clk_protect_pkg::IRQ_MASK_ADDR) ?
      wdata_in[clk_protect_pkg::IRQ_W-1:0] : mask_reg;
    // Read data for the next cycle only
    rdata_next = '0;
    if (rd_in) begin
      unique case (addr_in)
        clk_protect_pkg::WRITE_PROTECT_ADDR: begin
          rdata_next[clk_protect_pkg::CLK_UNLOCK_BIT] = clk_unlock_reg;
          rdata_next[clk_protect_pkg::MODE_UNLOCK_BIT] = mode_unlock_reg;
        end
        clk_protect_pkg::PROC_MODE2_ADDR: rdata_next[clk_protect_pkg::LOCK_BIT] = lock_reg;
        clk_protect_pkg::CLK_CTRL0_ADDR: begin
          rdata_next[clk_protect_pkg::WAIT_PERIPH_BIT] = wait_periph_reg;
          rdata_next[clk_protect_pkg::MAIN_HALT_BIT] = halt_reg;
          rdata_next[clk_protect_pkg::SUB_CPU_BIT] = sub_cpu_reg;
        end
        clk_protect_pkg::CLK_CTRL1_ADDR: begin
          rdata_next[clk_protect_pkg::ALL_STOP_BIT] = all_stop_reg;
          rdata_next[clk_protect_pkg::RING_STOP_BIT] = ring_stop_reg;
        end
        clk_protect_pkg::CLK_CTRL2_ADDR: begin
          rdata_next[clk_protect_pkg::DET_EN_BIT] = det_en_reg;
          rdata_next[clk_protect_pkg::RING_CPU_BIT] = ring_cpu_reg;
          rdata_next[clk_protect_pkg::EVT_FLAG_BIT] = flag_reg;
          rdata_next[clk_protect_pkg::MAIN_STATE_BIT] = main_state_reg;
          rdata_next[clk_protect_pkg::ACTION_BIT] = action_reg;
        end
        clk_protect_pkg::IRQ_STATUS_ADDR: rdata_next[clk_protect_pkg::IRQ_W-1:0] = status_reg;
        clk_protect_pkg::IRQ_MASK_ADDR: rdata_next[clk_protect_pkg::IRQ_W-1:0] = mask_reg;
        default: rdata_next = '0;
      endcase
    end
    // Held initialised after an oscillation stop reset
    if (hold_reg) begin
      clk_unlock_next = 1'b0;
      mode_unlock_next = 1'b0;
      lock_next = 1'b0;
      wait_periph_next = 1'b0;
      halt_next = 1'b0;
      sub_cpu_next = 1'b0;
      all_stop_next = 1'b0;
      ring_stop_next = clk_protect_pkg::RING_STOP_RST;
      det_en_next = 1'b0;
      action_next = 1'b0;
      ring_cpu_next = 1'b0;
      flag_next = 1'b0;
      main_state_next = 1'b0;
      status_next = clk_protect_pkg::IRQ_RST;
      mask_next = clk_protect_pkg::IRQ_RST;
      rdata_next = '0;
    end
    periph_ring_next = ring_cpu_next || (sub_cpu_next && main_state_next && flag_next);
    irq_next = wdt_irq_in || (|(status_next & mask_next));
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_unlock_reg <= 1'b0;
      mode_unlock_reg <= 1'b0;
      lock_reg <= 1'b0;
      wait_periph_reg <= 1'b0;
      halt_reg <= 1'b0;
      sub_cpu_reg <= 1'b0;
      all_stop_reg <= 1'b0;
      ring_stop_reg <= clk_protect_pkg::RING_STOP_RST;
      det_en_reg <= 1'b0;
      action_reg <= 1'b0;
      ring_cpu_reg <= 1'b0;
      flag_reg <= 1'b0;
      main_state_reg <= 1'b0;
      hold_reg <= 1'b0;
      periph_ring_reg <= 1'b0;
      irq_reg <= 1'b0;
      status_reg <= clk_protect_pkg::IRQ_RST;
      mask_reg <= clk_protect_pkg::IRQ_RST;
      rdata_reg <= '0;
      osc_prev_reg <= 1'b0;
      seen_reg <= 1'b0;
      win_reg <= '0;
    end else begin
      clk_unlock_reg <= clk_unlock_next;
      mode_unlock_reg <= mode_unlock_next;
      lock_reg <= lock_next;
      wait_periph_reg <= wait_periph_next;
      halt_reg <= halt_next;
      sub_cpu_reg <= sub_cpu_next;
      all_stop_reg <= all_stop_next;
      ring_stop_reg <= ring_stop_next;
      det_en_reg <= det_en_next;
      action_reg <= action_next;
      ring_cpu_reg <= ring_cpu_next;
      flag_reg <= flag_next;
      main_state_reg <= main_state_next;
      hold_reg <= hold_next;
      periph_ring_reg <= periph_ring_next;
      irq_reg <= irq_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
      osc_prev_reg <= main_osc_input_in;
      seen_reg <= seen_next;
      win_reg <= win_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign wait_periph_clock_stop_out = wait_periph_reg;
  assign main_clock_halt_out = halt_reg;
  assign subclock_cpu_select_out = sub_cpu_reg;
  assign all_clock_stop_out = all_stop_reg;
  assign ring_osc_stop_out = ring_stop_reg;
  assign ring_osc_cpu_select_out = ring_cpu_reg;
  assign periph_on_ring_out = periph_ring_reg;
  assign osc_stop_reset_out = hold_reg;
  assign irq_out = irq_reg;

  a_lock_cm0_bits: assert property (@(posedge clk_in) disable iff (rst_in)
    lock_reg && !hold_reg |=> $stable(halt_reg) && $stable(sub_cpu_reg) && $stable(det_en_reg))
    else $error("locked clock bit changed");
  a_pm2_protected: assert property (@(posedge clk_in) disable iff (rst_in)
    !mode_unlock_reg && !hold_reg |=> $stable(lock_reg))
    else $error("mode register written while protected");
  a_detect_off_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    !det_en_reg && !hold_reg |=> !hold_reg && $stable(flag_reg) || !flag_reg)
    else $error("detector acted while disabled");
  a_stop_reset_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_evt && !action_reg |=> osc_stop_reset_out [*4])
    else $error("stop reset not raised and held");
  a_stop_irq_state: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_evt && action_reg && !flag_reg && !sub_cpu_reg && !hold_reg
    |=> ring_osc_cpu_select_out && !ring_osc_stop_out && flag_reg && main_state_reg
    && (irq_out || !mask_reg[clk_protect_pkg::STOP_IRQ_BIT]))
    else $error("stop interrupt state wrong");
  a_reosc_keeps_cpu: assert property (@(posedge clk_in) disable iff (rst_in)
    reosc_evt && action_reg && !wr_in && !hold_reg
    |=> !main_state_reg && flag_reg && $stable(ring_cpu_reg))
    else $error("re-oscillation state wrong");
  a_flag_blocks_irq: assert property (@(posedge clk_in) disable iff (rst_in)
    flag_reg && !hold_reg && !(rd_in && addr_in == clk_protect_pkg::IRQ_STATUS_ADDR)
    |=> $stable(status_reg))
    else $error("interrupt raised while flag set");
  a_low_speed_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_evt && action_reg && !flag_reg && sub_cpu_reg && !wr_in && !hold_reg
    |=> subclock_cpu_select_out && periph_on_ring_out && $stable(ring_cpu_reg))
    else $error("low speed fallback wrong");
  a_window_bound: assert property (@(posedge clk_in) disable iff (rst_in)
    det_en_reg && win_reg == '0 && !hold_reg |-> ##[1:199] win_end || !det_en_reg)
    else $error("reference window overran");
  a_lock_other_bits: assert property (@(posedge clk_in) disable iff (rst_in)
    lock_reg && !hold_reg |=> $stable(wait_periph_reg) && $stable(all_stop_reg))
    else $error("locked stop bit changed");
  a_off_no_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    !det_en_reg && !hold_reg |=> !osc_stop_reset_out)
    else $error("stop reset while detection disabled");
  a_off_no_status: assert property (@(posedge clk_in) disable iff (rst_in)
    !det_en_reg && !hold_reg && !(rd_in && addr_in == clk_protect_pkg::IRQ_STATUS_ADDR)
    |=> $stable(status_reg))
    else $error("status changed while detection disabled");
  a_off_ring_kept: assert property (@(posedge clk_in) disable iff (rst_in)
    !det_en_reg && !hold_reg && !wr_in |=> $stable(ring_stop_reg))
    else $error("ring oscillator started while detection disabled");
  a_irq_no_reset: assert property (@(posedge clk_in) disable iff (rst_in)
    evt && action_reg && !hold_reg |=> !osc_stop_reset_out)
    else $error("stop reset with interrupt action");
  a_reset_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    osc_stop_reset_out |=> osc_stop_reset_out)
    else $error("stop reset released without hardware reset");
  a_hold_initialises: assert property (@(posedge clk_in) disable iff (rst_in)
    osc_stop_reset_out |=> status_reg == '0 && ring_osc_stop_out && !det_en_reg && !lock_reg)
    else $error("registers not initialised during stop reset");
  a_stop_main_state: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_evt && !hold_reg |=> main_state_reg)
    else $error("main clock state not set on stop");
  a_stop_status_set: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_evt && action_reg && !flag_reg && !hold_reg
    |=> status_reg[clk_protect_pkg::STOP_IRQ_BIT])
    else $error("stop interrupt request missing");
  a_reosc_main_state: assert property (@(posedge clk_in) disable iff (rst_in)
    reosc_evt && !hold_reg |=> !main_state_reg)
    else $error("main clock state not cleared on re-oscillation");
  a_reosc_irq_state: assert property (@(posedge clk_in) disable iff (rst_in)
    reosc_evt && action_reg && !flag_reg && !hold_reg
    |=> !ring_osc_stop_out && status_reg[clk_protect_pkg::REOSC_IRQ_BIT])
    else $error("re-oscillation interrupt request missing");
  a_shared_irq_line: assert property (@(posedge clk_in) disable iff (rst_in)
    wdt_irq_in |=> irq_out)
    else $error("watchdog request missing on shared line");
  a_irq_has_source: assert property (@(posedge clk_in) disable iff (rst_in)
    irq_out |-> $past(wdt_irq_in) || (|(status_reg & mask_reg)))
    else $error("interrupt line high without a source");
  a_event_sets_flag: assert property (@(posedge clk_in) disable iff (rst_in)
    irq_req && !hold_reg |=> flag_reg)
    else $error("event flag not set with interrupt");
  a_flag_holds_set: assert property (@(posedge clk_in) disable iff (rst_in)
    flag_reg && !hold_reg && !wr_in |=> flag_reg)
    else $error("event flag cleared without a write");
  a_low_speed_ring: assert property (@(posedge clk_in) disable iff (rst_in)
    stop_evt && action_reg && !flag_reg && sub_cpu_reg && !hold_reg
    |=> !ring_osc_stop_out && flag_reg && main_state_reg)
    else $error("ring oscillator not started in low speed mode");
endmodule : clock_protect_osc_stop_detect

/* tb/tb_top.sv */
// Self-checking bench for the clock protection lock and oscillation detector
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // Design inputs
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic main_osc_input_in = 1'b0;
  logic wdt_irq_in = 1'b0;
  // Design outputs
  logic [7:0] rdata_out;
  logic wait_periph_clock_stop_out, main_clock_halt_out, subclock_cpu_select_out;
  logic all_clock_stop_out, ring_osc_stop_out, ring_osc_cpu_select_out;
  logic periph_on_ring_out, osc_stop_reset_out, irq_out;
  // Bench state
  logic osc_run = 1'b1;
  logic [31:0] seed;
  logic [7:0] d;
  logic [7:0] a;
  int err_total = 0;
  int compares = 0;

  clock_protect_osc_stop_detect u_clock_protect_osc_stop_detect (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .main_osc_input_in(main_osc_input_in), .wdt_irq_in(wdt_irq_in),
    .wait_periph_clock_stop_out(wait_periph_clock_stop_out),
    .main_clock_halt_out(main_clock_halt_out),
    .subclock_cpu_select_out(subclock_cpu_select_out),
    .all_clock_stop_out(all_clock_stop_out), .ring_osc_stop_out(ring_osc_stop_out),
    .ring_osc_cpu_select_out(ring_osc_cpu_select_out),
    .periph_on_ring_out(periph_on_ring_out), .osc_stop_reset_out(osc_stop_reset_out),
    .irq_out(irq_out)
  );

  always #20 clk_in = ~clk_in;
  // Main oscillator stand-in, toggles while running
  always @(posedge clk_in) begin
    if (osc_run) begin
      main_osc_input_in <= ~main_osc_input_in;
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h00000000);
  endfunction : lfsr

  // Expected clock_ctrl_reg2 readback
  function automatic logic [7:0] ctrl2(input logic en, input logic ring, input logic flag,
                                       input logic state, input logic act);
    return {act, 3'h0, state, flag, ring, en};
  endfunction : ctrl2

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic ochk(input logic s, input logic e);
    chk({7'h00, s}, {7'h00, e});
  endtask : ochk

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= adr;
    wdata_in <= dat;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] adr, input logic [7:0] exp);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= adr;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask : rdchk

  // Bounded wait: 0 irq, 1 stop reset, 2 ring oscillator started
  task automatic wait_ev(input int which);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 600) begin
      @(negedge clk_in);
      n++;
      hit = (which == 0) ? (irq_out === 1'b1) :
            (which == 1) ? (osc_stop_reset_out === 1'b1) : (ring_osc_stop_out === 1'b0);
    end
    ochk(hit, 1'b1);
  endtask : wait_ev

  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask : do_reset

  task automatic test_done();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    test_done();
  end

  initial begin
    seed = 32'h4a089600;
    do_reset();
    @(negedge clk_in);
    ochk(ring_osc_stop_out, 1'b1);
    ochk(irq_out, 1'b0);
    // Protected writes dropped
    wr(8'h01, 8'h02);
    wr(8'h02, 8'ha4);
    rdchk(8'h01, 8'h00);
    rdchk(8'h02, 8'h00);
    // Lock sequence, then attempts on locked bits
    wr(8'h00, 8'h03);
    wr(8'h02, 8'h04);
    wr(8'h01, 8'h02);
    wr(8'h00, 8'h01);
    wr(8'h02, 8'ha0);
    wr(8'h03, 8'h11);
    wr(8'h04, 8'h01);
    wr(8'h01, 8'h00);
    @(negedge clk_in);
    ochk(wait_periph_clock_stop_out, 1'b1);
    ochk(main_clock_halt_out, 1'b0);
    ochk(subclock_cpu_select_out, 1'b0);
    ochk(all_clock_stop_out, 1'b0);
    rdchk(8'h02, 8'h04);
    rdchk(8'h04, 8'h00);
    rdchk(8'h01, 8'h02);
    // Release lock, random traffic incl. unmapped places
    wr(8'h00, 8'h03);
    wr(8'h01, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = seed[7:0];
      a = 8'h07 + {4'h0, seed[11:8]};
      wr(8'h02, d);
      wr(a, seed[23:16]);
      rdchk(8'h02, d & 8'ha4);
      rdchk(a, 8'h00);
      ochk(main_clock_halt_out, d[5]);
    end
    wr(8'h02, 8'h00);
    wr(8'h06, 8'h03);
    rdchk(8'h06, 8'h03);
    // Detection disabled, oscillator quiet
    osc_run = 1'b0;
    repeat (450) @(posedge clk_in);
    ochk(irq_out, 1'b0);
    ochk(ring_osc_stop_out, 1'b1);
    rdchk(8'h05, 8'h00);
    // Enable with interrupt action, oscillator running
    osc_run = 1'b1;
    wr(8'h04, ctrl2(1, 0, 0, 0, 1));
    repeat (450) @(posedge clk_in);
    ochk(irq_out, 1'b0);
    osc_run = 1'b0;
    wait_ev(2);
    ochk(ring_osc_cpu_select_out, 1'b1);
    ochk(periph_on_ring_out, 1'b1);
    rdchk(8'h04, ctrl2(1, 1, 1, 1, 1));
    wait_ev(0);
    rdchk(8'h05, 8'h01);
    // Re-oscillation while flag set gives no interrupt
    osc_run = 1'b1;
    repeat (450) @(posedge clk_in);
    rdchk(8'h05, 8'h00);
    rdchk(8'h04, ctrl2(1, 1, 1, 0, 1));
    ochk(irq_out, 1'b0);
    wr(8'h04, ctrl2(1, 1, 0, 0, 1));
    osc_run = 1'b0;
    wait_ev(0);
    rdchk(8'h05, 8'h01);
    wr(8'h04, ctrl2(1, 1, 0, 0, 1));
    osc_run = 1'b1;
    wait_ev(0);
    rdchk(8'h05, 8'h02);
    rdchk(8'h04, ctrl2(1, 1, 1, 0, 1));
    ochk(ring_osc_stop_out, 1'b0);
    wr(8'h04, ctrl2(1, 0, 1, 0, 1));
    @(negedge clk_in);
    ochk(ring_osc_cpu_select_out, 1'b0);
    ochk(periph_on_ring_out, 1'b0);
    // Watchdog request on the shared line, detector masked
    wr(8'h06, 8'h00);
    @(negedge clk_in);
    ochk(irq_out, 1'b0);
    @(posedge clk_in);
    wdt_irq_in <= 1'b1;
    repeat (3) @(negedge clk_in);
    ochk(irq_out, 1'b1);
    @(posedge clk_in);
    wdt_irq_in <= 1'b0;
    wr(8'h04, ctrl2(0, 0, 0, 0, 1));
    // Reset action, then halted until hardware reset
    do_reset();
    wr(8'h00, 8'h01);
    wr(8'h04, ctrl2(1, 0, 0, 0, 0));
    osc_run = 1'b0;
    wait_ev(1);
    wr(8'h02, 8'h04);
    repeat (20) @(negedge clk_in);
    ochk(osc_stop_reset_out, 1'b1);
    ochk(wait_periph_clock_stop_out, 1'b0);
    ochk(irq_out, 1'b0);
    osc_run = 1'b1;
    // Stop while CPU runs on the subclock
    @(posedge clk_in);
    do_reset();
    wr(8'h00, 8'h01);
    wr(8'h02, 8'h80);
    wr(8'h06, 8'h01);
    wr(8'h04, ctrl2(1, 0, 0, 0, 1));
    osc_run = 1'b0;
    wait_ev(0);
    ochk(subclock_cpu_select_out, 1'b1);
    ochk(periph_on_ring_out, 1'b1);
    ochk(ring_osc_stop_out, 1'b0);
    test_done();
  end
endmodule : tb_top
